// file: hw/rmr_top.sv
// reserved address range checker: range tables, drop counters, APB slave
`timescale 1ns/1ps
`include "rmr_defines.svh"

// Function
// [R1] entry matches when low bound <= address <= high bound
// [R2] two tables of four entries, all compared in parallel
// [R3] destination table checks destination address, gated by per-port enable mask
// [R4] source table checks source address, same layout, own per-port mask
// [R5] entries are evaluated starting from entry 0
// [R6] any matching entry with discard bit set drops the frame
// [R7] destination and source drops each count in their own counter
// [R8] any matching redirect bit sends frame to host port, over drop
// [R9] highest-numbered matching queue override entry supplies the queue number
// [R10] matching colour override entry sets the frame's initial colour
// [R11] matching meter-valid entry supplies meter pointer and pointer order
// [R12] each entry spans four register words, all readable and writable
// [R13] highest-numbered matching entry decides colour and meter pointer
// [R14] both tables merge with redirect over drop, any drop honoured
module rmr_top
    import rmr_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic   [31:0]  paddr,
    input  wire logic   [31:0]  pwdata,
    input  wire logic   [3:0]   pstrb,
    output logic        [31:0]  prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           frm_valid,
    input  wire logic   [47:0]  frm_dst_mac,
    input  wire logic   [47:0]  frm_src_mac,
    input  wire logic   [3:0]   frm_src_port,
    output logic                act_valid,
    output logic                act_drop,
    output logic                act_redirect_to_host,
    output logic                act_queue_override_on,
    output logic        [2:0]   act_override_queue_num,
    output logic                act_colour_override_on,
    output logic        [1:0]   act_colour,
    output logic                act_meter_ptr_valid,
    output logic        [5:0]   act_meter_pointer,
    output logic        [1:0]   act_meter_pointer_order,
    output logic                act_dst_hit,
    output logic                act_src_hit
);
    // decode helpers
    function automatic rmr_region_e region_of(input logic [29:0] idx);
        if (idx >= `RMR_SRC_BASE_IDX && idx <= `RMR_SRC_BASE_IDX + `RMR_TABLE_SPAN)
            return RMR_REG_SRC_TBL;
        else if (idx >= `RMR_DST_BASE_IDX && idx <= `RMR_DST_BASE_IDX + `RMR_TABLE_SPAN)
            return RMR_REG_DST_TBL;
        else if (idx == `RMR_SRC_CNT_IDX)
            return RMR_REG_SRC_CNT;
        else if (idx == `RMR_DST_CNT_IDX)
            return RMR_REG_DST_CNT;
        else
            return RMR_REG_NONE;
    endfunction

    function automatic logic [3:0] table_offset(input logic [29:0] idx,
                                                input logic [29:0] base);
        logic [29:0] diff;
        diff = idx - base;
        return diff[3:0];
    endfunction

    function automatic logic [31:0] entry_word(input rmr_entry_t e, input logic [1:0] w);
        logic [127:0] wide;
        wide = {3'b000, e};
        return wide[{w, 5'b00000} +: 32];
    endfunction

    // merge one word into an entry under byte strobes; bits past 124 are dropped
    function automatic rmr_entry_t entry_merge(input rmr_entry_t e, input logic [1:0] w,
                                               input logic [31:0] d, input logic [3:0] s);
        logic [127:0] wide;
        wide = {3'b000, e};
        for (int b = 0; b < 4; b++) begin
            if (s[b])
                wide[{w, 5'b00000} + 7'(b * 8) +: 8] = d[b*8 +: 8];
        end
        return wide[124:0];
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b])
                r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    // table storage
    rmr_entry_t   src_tbl_q [`RMR_ENTRIES];
    rmr_entry_t   src_tbl_d [`RMR_ENTRIES];
    rmr_entry_t   dst_tbl_q [`RMR_ENTRIES];
    rmr_entry_t   dst_tbl_d [`RMR_ENTRIES];
    logic [31:0]  src_cnt_q;
    logic [31:0]  src_cnt_d;
    logic [31:0]  dst_cnt_q;
    logic [31:0]  dst_cnt_d;

    logic [29:0]  word_idx;
    rmr_region_e  region;
    logic [3:0]   src_off;
    logic [3:0]   dst_off;
    logic         wr_go;

    assign word_idx = paddr[31:2];
    assign region   = region_of(word_idx);
    assign src_off  = table_offset(word_idx, `RMR_SRC_BASE_IDX);
    assign dst_off  = table_offset(word_idx, `RMR_DST_BASE_IDX);
    // a write lands only at the access edge of a mapped address
    assign wr_go    = psel && penable && pready && pwrite && (region != RMR_REG_NONE);

    // range compare
    logic        d_hit, d_drop, d_redir, d_qon, d_colon, d_mv;
    logic [2:0]  d_qnum;
    logic [1:0]  d_col, d_mord;
    logic [5:0]  d_mptr;
    logic        s_hit, s_drop, s_redir, s_qon, s_colon, s_mv;
    logic [2:0]  s_qnum;
    logic [1:0]  s_col, s_mord;
    logic [5:0]  s_mptr;

    rmr_range_table u_dst_tbl (
        .mac                 (frm_dst_mac),       // [R3]
        .src_port            (frm_src_port),
        .entries             (dst_tbl_q),
        .hit                 (d_hit),
        .drop                (d_drop),
        .redirect            (d_redir),
        .queue_on            (d_qon),
        .queue_num           (d_qnum),
        .colour_on           (d_colon),
        .colour              (d_col),
        .meter_valid         (d_mv),
        .meter_pointer       (d_mptr),
        .meter_pointer_order (d_mord)
    );

    rmr_range_table u_src_tbl (
        .mac                 (frm_src_mac),       // [R4]
        .src_port            (frm_src_port),
        .entries             (src_tbl_q),
        .hit                 (s_hit),
        .drop                (s_drop),
        .redirect            (s_redir),
        .queue_on            (s_qon),
        .queue_num           (s_qnum),
        .colour_on           (s_colon),
        .colour              (s_col),
        .meter_valid         (s_mv),
        .meter_pointer       (s_mptr),
        .meter_pointer_order (s_mord)
    );

    logic any_redir;
    logic final_drop;
    assign any_redir  = d_redir | s_redir;                          // [R14]
    assign final_drop = (d_drop | s_drop) & ~any_redir;             // [R8] [R14]

    // table and counters
    always_comb begin
        src_tbl_d = src_tbl_q;
        dst_tbl_d = dst_tbl_q;
        src_cnt_d = src_cnt_q;
        dst_cnt_d = dst_cnt_q;
        if (wr_go) begin
            unique case (region)
                RMR_REG_SRC_TBL:
                    src_tbl_d[src_off[3:2]] = entry_merge(src_tbl_q[src_off[3:2]],
                                                          src_off[1:0], pwdata, pstrb); // [R12]
                RMR_REG_DST_TBL:
                    dst_tbl_d[dst_off[3:2]] = entry_merge(dst_tbl_q[dst_off[3:2]],
                                                          dst_off[1:0], pwdata, pstrb); // [R12]
                RMR_REG_SRC_CNT:
                    src_cnt_d = strb_merge(src_cnt_q, pwdata, pstrb);
                RMR_REG_DST_CNT:
                    dst_cnt_d = strb_merge(dst_cnt_q, pwdata, pstrb);
                RMR_REG_NONE: ;
            endcase
        end
        // a drop in the same cycle as a software write still counts
        if (frm_valid && final_drop && d_drop)
            dst_cnt_d = dst_cnt_d + 32'h0000_0001;                  // [R7]
        if (frm_valid && final_drop && s_drop)
            src_cnt_d = src_cnt_d + 32'h0000_0001;                  // [R7]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `RMR_ENTRIES; i++) begin
                src_tbl_q[i] <= `RMR_ENTRY_RESET;
                dst_tbl_q[i] <= `RMR_ENTRY_RESET;
            end
            src_cnt_q <= `RMR_CNT_RESET;
            dst_cnt_q <= `RMR_CNT_RESET;
        end else begin
            src_tbl_q <= src_tbl_d;
            dst_tbl_q <= dst_tbl_d;
            src_cnt_q <= src_cnt_d;
            dst_cnt_q <= dst_cnt_d;
        end
    end

    // APB answer
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;

    // answer is prepared in the setup cycle so the access phase completes at once
    always_comb begin
        pready_d  = psel && !penable;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (region)
                RMR_REG_SRC_TBL: prdata_d = pwrite ? 32'h0000_0000 :
                                 entry_word(src_tbl_q[src_off[3:2]], src_off[1:0]); // [R12]
                RMR_REG_DST_TBL: prdata_d = pwrite ? 32'h0000_0000 :
                                 entry_word(dst_tbl_q[dst_off[3:2]], dst_off[1:0]); // [R12]
                RMR_REG_SRC_CNT: prdata_d = pwrite ? 32'h0000_0000 : src_cnt_q;
                RMR_REG_DST_CNT: prdata_d = pwrite ? 32'h0000_0000 : dst_cnt_q;
                RMR_REG_NONE:    pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // frame actions
    logic        act_valid_d, act_drop_d, act_redir_d, act_qon_d, act_colon_d, act_mv_d;
    logic [2:0]  act_qnum_d;
    logic [1:0]  act_col_d, act_mord_d;
    logic [5:0]  act_mptr_d;
    logic        act_dhit_d, act_shit_d;

    // source table values override destination table values where both apply
    always_comb begin
        act_valid_d = frm_valid;
        act_drop_d  = frm_valid & final_drop;                       // [R6] [R14]
        act_redir_d = frm_valid & any_redir;                        // [R8]
        act_dhit_d  = frm_valid & d_hit;
        act_shit_d  = frm_valid & s_hit;
        act_qon_d   = frm_valid & (d_qon | s_qon);                  // [R9]
        act_qnum_d  = s_qon ? s_qnum : d_qnum;                      // [R9] [R14]
        act_colon_d = frm_valid & (d_colon | s_colon);              // [R10]
        act_col_d   = s_colon ? s_col : d_col;                      // [R10] [R14]
        act_mv_d    = frm_valid & (d_mv | s_mv);                    // [R11]
        act_mptr_d  = s_mv ? s_mptr : d_mptr;                       // [R11] [R14]
        act_mord_d  = s_mv ? s_mord : d_mord;                       // [R11] [R14]
        if (!frm_valid) begin
            act_qnum_d = 3'h0;
            act_col_d  = 2'h0;
            act_mptr_d = 6'h00;
            act_mord_d = 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_valid               <= 1'b0;
            act_drop                <= 1'b0;
            act_redirect_to_host    <= 1'b0;
            act_queue_override_on   <= 1'b0;
            act_override_queue_num  <= 3'h0;
            act_colour_override_on  <= 1'b0;
            act_colour              <= 2'h0;
            act_meter_ptr_valid     <= 1'b0;
            act_meter_pointer       <= 6'h00;
            act_meter_pointer_order <= 2'h0;
            act_dst_hit             <= 1'b0;
            act_src_hit             <= 1'b0;
        end else begin
            act_valid               <= act_valid_d;
            act_drop                <= act_drop_d;
            act_redirect_to_host    <= act_redir_d;
            act_queue_override_on   <= act_qon_d;
            act_override_queue_num  <= act_qnum_d;
            act_colour_override_on  <= act_colon_d;
            act_colour              <= act_col_d;
            act_meter_ptr_valid     <= act_mv_d;
            act_meter_pointer       <= act_mptr_d;
            act_meter_pointer_order <= act_mord_d;
            act_dst_hit             <= act_dhit_d;
            act_src_hit             <= act_shit_d;
        end
    end
endmodule // rmr_top

// file: hw/rmr_defines.svh
// register indices, field positions and sizes of the reserved address range checker
`ifndef RMR_DEFINES_SVH
`define RMR_DEFINES_SVH

`define RMR_ENTRIES       4
`define RMR_WORDS         4
`define RMR_ENTRY_W       125
`define RMR_PORTS         11
`define RMR_PORT_W        4

`define RMR_SRC_BASE_IDX  30'h0011214B
`define RMR_DST_BASE_IDX  30'h0011215B
`define RMR_SRC_CNT_IDX   30'h00112170
`define RMR_DST_CNT_IDX   30'h00112171
`define RMR_TABLE_SPAN    30'h0000000F

`define RMR_F_LOW         0
`define RMR_F_HIGH        48
`define RMR_F_DROP        96
`define RMR_F_HOST        97
`define RMR_F_QON         98
`define RMR_F_QNUM        99
`define RMR_F_COL         102
`define RMR_F_COLON       104
`define RMR_F_MVALID      105
`define RMR_F_MPTR        106
`define RMR_F_MORD        112
`define RMR_F_EN          114

`define RMR_ENTRY_RESET   125'h0
`define RMR_CNT_RESET     32'h0000_0000

`endif

// file: hw/rmr_pkg.sv
// types shared by the reserved address range checker
package rmr_pkg;
    typedef logic [124:0] rmr_entry_t;
    typedef logic [47:0]  rmr_mac_t;
    typedef enum logic [2:0] {
        RMR_REG_NONE    = 3'b000,
        RMR_REG_SRC_TBL = 3'b001,
        RMR_REG_DST_TBL = 3'b010,
        RMR_REG_SRC_CNT = 3'b011,
        RMR_REG_DST_CNT = 3'b100
    } rmr_region_e;
endpackage

// file: hw/rmr_range_table.sv
// one table of four address ranges: parallel compare and action merge
`timescale 1ns/1ps
`include "rmr_defines.svh"

module rmr_range_table
    import rmr_pkg::*;
(
    input  wire logic       [47:0]  mac,
    input  wire logic       [3:0]   src_port,
    input  wire rmr_entry_t         entries [`RMR_ENTRIES],
    output logic                    hit,
    output logic                    drop,
    output logic                    redirect,
    output logic                    queue_on,
    output logic            [2:0]   queue_num,
    output logic                    colour_on,
    output logic            [1:0]   colour,
    output logic                    meter_valid,
    output logic            [5:0]   meter_pointer,
    output logic            [1:0]   meter_pointer_order
);
    logic [`RMR_ENTRIES-1:0] match;
    logic [10:0]             port_bit;

    assign port_bit = (src_port < 4'd11) ? (11'h001 << src_port) : 11'h000;

    // all four entries compared in the same cycle [R2]
    always_comb begin
        for (int i = 0; i < `RMR_ENTRIES; i++) begin
            match[i] = (mac >= entries[i][`RMR_F_LOW +: 48]) &&     // [R1]
                       (mac <= entries[i][`RMR_F_HIGH +: 48]) &&    // [R1]
                       ((entries[i][`RMR_F_EN +: 11] & port_bit) != 11'h000); // [R3] [R4]
        end
    end

    always_comb begin
        hit                 = 1'b0;
        drop                = 1'b0;
        redirect            = 1'b0;
        queue_on            = 1'b0;
        queue_num           = 3'h0;
        colour_on           = 1'b0;
        colour              = 2'h0;
        meter_valid         = 1'b0;
        meter_pointer       = 6'h00;
        meter_pointer_order = 2'h0;
        // walk from entry 0 upward so later matches overwrite earlier ones [R5]
        for (int i = 0; i < `RMR_ENTRIES; i++) begin
            if (match[i]) begin
                hit      = 1'b1;
                drop     = drop | entries[i][`RMR_F_DROP];          // [R6]
                redirect = redirect | entries[i][`RMR_F_HOST];      // [R8]
                if (entries[i][`RMR_F_QON]) begin
                    queue_on  = 1'b1;                               // [R9]
                    queue_num = entries[i][`RMR_F_QNUM +: 3];       // [R9]
                end
                if (entries[i][`RMR_F_COLON]) begin
                    colour_on = 1'b1;                               // [R10] [R13]
                    colour    = entries[i][`RMR_F_COL +: 2];        // [R10] [R13]
                end
                if (entries[i][`RMR_F_MVALID]) begin
                    meter_valid         = 1'b1;                     // [R11] [R13]
                    meter_pointer       = entries[i][`RMR_F_MPTR +: 6]; // [R11]
                    meter_pointer_order = entries[i][`RMR_F_MORD +: 2]; // [R11]
                end
            end
        end
    end
endmodule // rmr_range_table

// file: tb/rmr_top_sva.sv
// port checker for the reserved address range block
`timescale 1ns/1ps
`include "rmr_defines.svh"

module rmr_top_chk (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        frm_valid,
    input logic [3:0]  frm_src_port,
    input logic        act_valid,
    input logic        act_drop,
    input logic        act_redirect_to_host,
    input logic        act_dst_hit,
    input logic        act_src_hit
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [29:0] off;
    logic        in_tbl;
    logic        mapped;
    assign off    = paddr[31:2] - `RMR_SRC_BASE_IDX;
    assign in_tbl = off < 30'h20;
    assign mapped = in_tbl || paddr[31:2] == `RMR_SRC_CNT_IDX || paddr[31:2] == `RMR_DST_CNT_IDX;

    AST_ACT_LATENCY: assert property (frm_valid |=> act_valid)
        else $error("late action");
    AST_ACT_CAUSE: assert property (act_valid |-> $past(frm_valid))
        else $error("stray action");
    AST_REDIRECT_WINS: assert property (act_valid && act_redirect_to_host |-> !act_drop)
        else $error("drop with redirect");
    AST_ACTION_NEEDS_HIT: assert property (
        act_drop || act_redirect_to_host |-> act_dst_hit || act_src_hit)
        else $error("action without hit");
    AST_PORT_GATE: assert property (
        frm_valid && frm_src_port > 4'hA |=> !act_dst_hit && !act_src_hit)
        else $error("hit on masked port");
    AST_QUIET_IDLE: assert property (
        !act_valid |-> !(act_drop || act_redirect_to_host || act_dst_hit))
        else $error("idle action");
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("long ready");
    AST_ERR_UNMAPPED: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("no error");
    AST_NO_ERR_MAPPED: assert property (pready && mapped |-> !pslverr)
        else $error("false error");
    AST_RSVD_ZERO: assert property (
        pready && !pwrite && in_tbl && off[1:0] == 2'h3 |-> prdata[31:29] == 3'h0)
        else $error("unused bits set");

    COV_DROP: cover property (act_drop && act_dst_hit && act_src_hit);
    COV_REDIRECT: cover property (act_redirect_to_host);
    COV_ERR: cover property (pslverr);
endmodule // rmr_top_chk

bind rmr_top rmr_top_chk chk_u (.*);

// file: tb/rmr_pipe_model.sv
// ingress pipeline model: presents frames to the range checker
`timescale 1ns/1ps

module rmr_pipe_model (
    input  wire logic        pclk,
    output logic             frm_valid,
    output logic      [47:0] frm_dst_mac,
    output logic      [47:0] frm_src_mac,
    output logic      [3:0]  frm_src_port
);
    initial {frm_valid, frm_dst_mac, frm_src_mac, frm_src_port} = '0;

    // hold keeps the strobe up so the next frame follows back to back
    task automatic send(input logic [47:0] d, input logic [47:0] s, input logic [3:0] p,
                        input bit hold);
        @(posedge pclk);
        frm_valid <= 1'b1;
        frm_dst_mac <= d;
        frm_src_mac <= s;
        frm_src_port <= p;
        if (!hold) begin
            @(posedge pclk);
            frm_valid <= 1'b0;
            // released fields must not look like the last frame
            frm_dst_mac <= ~d;
            frm_src_mac <= ~s;
            frm_src_port <= ~p;
        end
    endtask
endmodule // rmr_pipe_model

// file: tb/reserved_mac_range_check_test.sv
// self-checking bench for the reserved address range block
`timescale 1ns/1ps
`include "rmr_defines.svh"

module reserved_mac_range_check_test
    import rmr_pkg::*;
;
    localparam logic [29:0] SRC = `RMR_SRC_BASE_IDX;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready, pslverr, frm_valid;
    rmr_mac_t    frm_dst_mac;
    rmr_mac_t    frm_src_mac;
    logic [3:0]  frm_src_port;
    logic        act_valid;
    wire  [19:0] act;
    rmr_entry_t  tbl [2][4];
    logic [31:0] cnt [2];
    logic [19:0] exp_act [$];
    logic [32:0] rd_q [$];
    logic [31:0] rs = 32'h0000_0009;
    logic [15:0] pfx;
    int          checks, miscompares;

    rmr_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frm_valid(frm_valid), .frm_dst_mac(frm_dst_mac),
        .frm_src_mac(frm_src_mac), .frm_src_port(frm_src_port), .act_valid(act_valid),
        .act_drop(act[19]), .act_redirect_to_host(act[18]), .act_queue_override_on(act[17]),
        .act_override_queue_num(act[16:14]), .act_colour_override_on(act[13]),
        .act_colour(act[12:11]), .act_meter_ptr_valid(act[10]), .act_meter_pointer(act[9:4]),
        .act_meter_pointer_order(act[3:2]), .act_dst_hit(act[1]), .act_src_hit(act[0])
    );

    rmr_pipe_model pipe_u (
        .pclk(pclk), .frm_valid(frm_valid), .frm_dst_mac(frm_dst_mac),
        .frm_src_mac(frm_src_mac), .frm_src_port(frm_src_port)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // narrow ranges sharing one upper prefix, so entries overlap often
    function automatic rmr_entry_t mk();
        logic [31:0] r;
        logic [31:0] f;
        rmr_mac_t    lo;
        r = rnd();
        f = rnd();
        lo = {pfx, 24'h0, r[7:0]};
        return {f[28:18], f[17:0], lo + {40'h0, r[15:8]}, lo};
    endfunction

    function automatic rmr_mac_t pick();
        logic [31:0] r;
        rmr_entry_t  e;
        r = rnd();
        e = tbl[r[0]][r[2:1]];
        case (r[5:3])
            3'h0: return e[47:0];
            3'h1: return e[95:48];
            3'h2: return e[47:0] - 48'h1;
            3'h3: return e[95:48] + 48'h1;
            3'h4: return {r[31:16], rnd()};
            default: return {pfx, 23'h0, r[31:23]};
        endcase
    endfunction

    // unused fields are cleared so only meaningful values are compared
    function automatic logic [19:0] norm(input logic [19:0] a);
        if (a[17] !== 1'b1) a[16:14] = 3'h0;
        if (a[13] !== 1'b1) a[12:11] = 2'h0;
        if (a[10] !== 1'b1) a[9:2] = 8'h0;
        return a;
    endfunction

    function automatic logic [19:0] expect_act(input rmr_mac_t d, input rmr_mac_t s,
                                               input logic [3:0] p, output logic [1:0] dr);
        logic [19:0] a;
        rmr_mac_t    m;
        rmr_entry_t  e;
        a = 20'h0;
        dr = 2'h0;
        for (int t = 1; t >= 0; t--) begin
            m = t[0] ? d : s;
            for (int i = 0; i < 4; i++) begin
                e = tbl[t][i];
                if (p < 4'hB && e[114 + p] && m >= e[47:0] && m <= e[95:48]) begin
                    a[t] = 1'b1;
                    dr[t] = dr[t] | e[96];
                    a[18] = a[18] | e[97];
                    if (e[98]) a[17:14] = {1'b1, e[101:99]};
                    if (e[104]) a[13:11] = {1'b1, e[103:102]};
                    if (e[105]) a[10:2] = {1'b1, e[111:106], e[113:112]};
                end
            end
        end
        a[19] = |dr & !a[18];
        return a;
    endfunction

    task automatic bad(input string m);
        miscompares = miscompares + 1;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic frame(input rmr_mac_t d, input rmr_mac_t s, input logic [3:0] p, input bit hold);
        logic [1:0]  dr;
        logic [19:0] a;
        a = expect_act(d, s, p, dr);
        for (int t = 0; t < 2; t++) if (dr[t] && !a[18]) cnt[t] = cnt[t] + 32'h1;
        exp_act.push_back(norm(a));
        pipe_u.send(d, s, p, hold);
    endtask

    task automatic apb(input bit wr, input logic [29:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
        logic [29:0]  off;
        logic [127:0] ent;
        logic [31:0]  rv;
        logic         hit;
        off = idx - SRC;
        ent = {3'h0, tbl[off[4]][off[3:2]]};
        hit = off < 30'h20 || idx == `RMR_SRC_CNT_IDX || idx == `RMR_DST_CNT_IDX;
        rv = idx == `RMR_SRC_CNT_IDX ? cnt[0] :
             idx == `RMR_DST_CNT_IDX ? cnt[1] : ent[32*off[1:0] +: 32];
        if (wr) begin
            for (int b = 0; b < 4; b++) if (st[b]) rv[8*b +: 8] = wd[8*b +: 8];
            ent[32*off[1:0] +: 32] = rv;
            if (off < 30'h20) tbl[off[4]][off[3:2]] = ent[124:0];
            if (idx == `RMR_SRC_CNT_IDX) cnt[0] = rv;
            if (idx == `RMR_DST_CNT_IDX) cnt[1] = rv;
        end
        rd_q.push_back(hit ? {1'b0, wr ? 32'h0 : rv} : {1'b1, 32'h0});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) bad("no ready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic end_sim();
        if (exp_act.size() != 0 || rd_q.size() != 0) bad("results missing");
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (act_valid === 1'b1) begin
            checks = checks + 1;
            if (exp_act.size() == 0) bad("stray action");
            else if (norm(act) !== exp_act.pop_front()) bad("action mismatch");
        end
        if (psel && penable && pready === 1'b1) begin
            checks = checks + 1;
            if (rd_q.size() == 0) bad("stray response");
            else if ({pslverr, prdata} !== rd_q.pop_front()) bad("apb mismatch");
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        bad("timeout");
        end_sim();
    end

    initial begin
        logic [31:0]  r;
        logic [127:0] ew;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        checks = 0;
        miscompares = 0;
        pfx = 16'h0;
        ew = 128'h0;
        tbl = '{default: '0};
        cnt = '{default: '0};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, SRC - 30'h1, 32'h0, 4'hF);
        for (int k = 0; k < 39; k++) apb(1'b0, SRC + 30'(k), 32'h0, 4'hF);
        for (int rd = 0; rd < 4; rd++) begin
            r = rnd();
            pfx = r[15:0];
            for (int w = 0; w < 32; w++) begin
                if (w[1:0] == 2'h0) ew = {r[31:29], mk()};
                apb(1'b1, SRC + 30'(w), ew[32*w[1:0] +: 32], 4'hF);
            end
            for (int w = 0; w < 32; w++) apb(1'b0, SRC + 30'(w), 32'h0, 4'hF);
            for (int n = 0; n < 120; n++) frame(pick(), pick(), 4'(rnd()), n % 6 != 5);
            apb(1'b0, `RMR_SRC_CNT_IDX, 32'h0, 4'hF);
            apb(1'b0, `RMR_DST_CNT_IDX, 32'h0, 4'hF);
            for (int n = 0; n < 8; n++) begin
                r = rnd();
                apb(1'b1, SRC + 30'(r[15:0] % 39), rnd(), r[19:16]);
                apb(1'b0, SRC + 30'(r[15:0] % 39), 32'h0, 4'hF);
            end
        end
        repeat (4) @(posedge pclk);
        end_sim();
    end
endmodule // reserved_mac_range_check_test
